// ### core/samf_framer.sv
`timescale 1ns/100ps
// Overview of operation
// [R1] both straps open, no override: 17-byte '#AL' message, 1200 baud 8N1
// [R2] second strap grounded: 10-byte 'ALT' message at 9600 8N1, disabled reads 99900
// [R3] first strap grounded: 10-byte 'ALT' message at 2400 8N1, disabled reads -2500
// [R4] both straps grounded: 17-byte '$MGL' message, 1200 baud 7E1
// [R5] software alternative with straps open: 24-byte '$PASHS' meters message, 9600 8N1
// [R6] differential output carries the primary output's message simultaneously
// [R7] secondary output always sends one fixed format at 1-foot resolution
// [R8] selectable outputs use 100-foot steps, 10-foot while resolution strap grounded
// [R9] software setting may select serial resolution instead of the strap
// [R10] bit rate 1200 to 9600 baud, set by the selected protocol
// [R11] about one message per second; ten per second when the selectable output runs at 9600
// [R12] every character has start and stop bits; bits, parity, rate follow protocol
// [R13] outputs are transmit only; nothing is expected back
// [R14] altitude as zero-padded ASCII digits; checksum as two hex characters
// [R15] settings sampled only between messages; a running message finishes unchanged
module samf_framer
    import samf_pkg::*;
#(
    parameter int unsigned FAST_PERIOD = FAST_PERIOD_CYC
)
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic proto_strap_a_n_i,
    input wire logic proto_strap_b_n_i,
    input wire logic res_strap_n_i,
    input wire logic sw_proto_en_i,
    input wire logic [2:0] sw_proto_i,
    input wire logic sw_res_en_i,
    input wire logic sw_res_fine_i,
    input wire logic signed [17:0] alt_ft_i,
    input wire logic alt_disabled_i,
    output logic primary_serial_out_o,
    output logic diff_serial_out_o,
    output logic fixed_format_serial_out_o,
    output logic primary_busy_o,
    output logic fixed_busy_o,
    output logic [2:0] active_proto_o
);

    function automatic logic [7:0] str_at(input logic [87:0] s, input int unsigned n, input int unsigned k);
        str_at = s[8 * (n - 1 - k) +: 8];
    endfunction

    function automatic logic [7:0] hex_char(input logic [3:0] n);
        hex_char = (n < 4'hA) ? 8'(8'h30 + n) : 8'(8'h37 + n);
    endfunction

    function automatic samf_fmt_type fmt_of(input samf_proto_type p);
        case (p)
            PROTO_HASH_AL: fmt_of = '{DIV_SLOW, 1'b0, LEN_HASH, CKS_HASH};
            PROTO_ALT_FAST: fmt_of = '{DIV_FAST, 1'b0, LEN_ALT, CKS_NONE};
            PROTO_ALT_SLOW: fmt_of = '{DIV_MID, 1'b0, LEN_ALT, CKS_NONE};
            PROTO_MGL: fmt_of = '{DIV_SLOW, 1'b1, LEN_MGL, CKS_MGL};
            PROTO_PASHS: fmt_of = '{DIV_FAST, 1'b0, LEN_PASHS, CKS_PASHS};
            default: fmt_of = '{DIV_FAST, 1'b0, LEN_FIXED, CKS_NONE};
        endcase
    endfunction

    // start bit in bit 0, sent lsb first; 7E1 and 8N1 are both ten bits long
    function automatic logic [9:0] frame_of(input logic [7:0] b, input logic par);
        frame_of = par ? {1'b1, ^b[6:0], b[6:0], 1'b0} : {1'b1, b, 1'b0}; // [R12]
    endfunction

    function automatic logic [47:0] build_field(input samf_proto_type p, input logic fine, input logic dis,
                                                input logic signed [17:0] alt);
        int unsigned mag;
        int unsigned res;
        int unsigned q;
        int unsigned d;
        logic neg;
        logic [39:0] dig;
        logic [47:0] f;
        neg = alt[17];
        mag = neg ? unsigned'(-int'(alt)) : unsigned'(int'(alt));
        res = (p == PROTO_FIXED) ? RES_FIXED_FT : (fine ? RES_FINE_FT : RES_COARSE_FT); // [R7] [R8]
        q = (mag + res / 2) / res * res;
        if (p == PROTO_PASHS)
        begin
            q = (q * FT_TO_M_NUM + FT_TO_M_DEN / 2) / FT_TO_M_DEN; // [R5]
        end
        neg = neg && (q != 0);
        d = q % FIELD_MOD;
        for (int k = 0; k < 5; k++)
        begin
            dig[8 * k +: 8] = 8'(CH_ZERO + 8'(d % 10)); // [R14]
            d = d / 10;
        end
        if (p == PROTO_ALT_FAST || p == PROTO_ALT_SLOW)
        begin
            if (dis)
            begin
                f = {CH_SPACE, (p == PROTO_ALT_FAST) ? DIS_ALT_FAST : DIS_ALT_SLOW}; // [R2] [R3]
            end
            else if (neg)
            begin
                f = {CH_SPACE, "-", dig[31:0]};
            end
            else
            begin
                f = {CH_SPACE, dig};
            end
        end
        else
        begin
            f = {neg ? "-" : "+", dig};
        end
        build_field = f;
    endfunction

    function automatic logic [7:0] msg_byte(input samf_proto_type p, input logic [4:0] i, input logic [47:0] f,
                                            input logic [7:0] cs);
        int unsigned k;
        logic [7:0] b;
        k = i;
        b = CH_CR;
        case (p)
            PROTO_HASH_AL, PROTO_MGL:
            begin
                if (k < 4) b = str_at((p == PROTO_HASH_AL) ? HEAD_HASH : HEAD_MGL, 4, k); // [R1] [R4]
                else if (k < 10) b = f[8 * (9 - k) +: 8];
                else if (k < 14) b = str_at(TAIL_T25, 4, k - 10);
                else if (k == 14) b = hex_char(cs[7:4]); // [R14]
                else if (k == 15) b = hex_char(cs[3:0]);
            end
            PROTO_ALT_FAST, PROTO_ALT_SLOW:
            begin
                if (k < 4) b = str_at(HEAD_ALT, 4, k); // [R2] [R3]
                else if (k < 9) b = f[8 * (8 - k) +: 8];
            end
            PROTO_PASHS:
            begin
                if (k == 0) b = CH_STX; // [R5]
                else if (k < 12) b = str_at(HEAD_PASHS, 11, k - 1);
                else if (k < 18) b = f[8 * (17 - k) +: 8];
                else if (k == 18) b = "*";
                else if (k == 19) b = hex_char(cs[7:4]);
                else if (k == 20) b = hex_char(cs[3:0]);
                else if (k == 22) b = CH_LF;
                else if (k == 23) b = CH_ETX;
            end
            default:
            begin
                if (k < 3) b = str_at(HEAD_FIXED, 3, k); // [R7]
                else if (k < 9) b = f[8 * (8 - k) +: 8];
            end
        endcase
        msg_byte = b;
    endfunction

    samf_proto_type sel_proto;
    logic sel_fine;
    logic fast_tick;
    logic slow_tick;
    logic [23:0] tick_cnt_r, tick_cnt_nxt;
    logic [3:0] dec_cnt_r, dec_cnt_nxt;
    // channel 0 is the selectable output, channel 1 the fixed one
    logic active_r[2], active_nxt[2];
    logic [4:0] idx_r[2], idx_nxt[2];
    logic [3:0] bitn_r[2], bitn_nxt[2];
    logic [13:0] baud_r[2], baud_nxt[2];
    logic [9:0] shift_r[2], shift_nxt[2];
    logic [7:0] cur_r[2], cur_nxt[2];
    logic [7:0] csum_r[2], csum_nxt[2];
    logic line_r[2], line_nxt[2];
    samf_msg_type msg_r[2], msg_nxt[2];

    always_comb
    begin
        case ({~proto_strap_a_n_i, ~proto_strap_b_n_i})
            2'b01: sel_proto = PROTO_ALT_FAST; // [R2]
            2'b10: sel_proto = PROTO_ALT_SLOW; // [R3]
            2'b11: sel_proto = PROTO_MGL; // [R4]
            default:
            begin
                sel_proto = PROTO_HASH_AL; // [R1]
                if (sw_proto_en_i && sw_proto_i < 3'h5)
                begin
                    sel_proto = samf_proto_type'(sw_proto_i); // [R5]
                end
            end
        endcase
        sel_fine = sw_res_en_i ? sw_res_fine_i : ~res_strap_n_i; // [R8] [R9]
    end

    always_comb
    begin
        fast_tick = (tick_cnt_r == 24'(FAST_PERIOD - 1));
        slow_tick = fast_tick && (dec_cnt_r == 4'(SLOW_PER_FAST - 4'h1));
        tick_cnt_nxt = fast_tick ? 24'h000000 : 24'(tick_cnt_r + 24'h000001);
        dec_cnt_nxt = dec_cnt_r;
        if (fast_tick)
        begin
            dec_cnt_nxt = slow_tick ? 4'h0 : 4'(dec_cnt_r + 4'h1);
        end
    end

    always_comb
    begin
        samf_msg_type m;
        samf_fmt_type f;
        logic start;
        logic [7:0] b;
        logic [7:0] cs;
        m = msg_r[0];
        f = fmt_of(m.proto);
        start = 1'b0;
        b = 8'h00;
        cs = 8'h00;
        for (int ch = 0; ch < 2; ch++)
        begin
            active_nxt[ch] = active_r[ch];
            idx_nxt[ch] = idx_r[ch];
            bitn_nxt[ch] = bitn_r[ch];
            baud_nxt[ch] = baud_r[ch];
            shift_nxt[ch] = shift_r[ch];
            cur_nxt[ch] = cur_r[ch];
            csum_nxt[ch] = csum_r[ch];
            line_nxt[ch] = line_r[ch];
            msg_nxt[ch] = msg_r[ch];
            if (!active_r[ch])
            begin
                line_nxt[ch] = 1'b1;
                if (ch == 0)
                begin
                    m.proto = sel_proto; // [R15]
                    m.fine = sel_fine;
                end
                else
                begin
                    m.proto = PROTO_FIXED; // [R7]
                    m.fine = 1'b0;
                end
                // 9600 baud protocols on the selectable output get the 100 ms slot, others (the fixed output too) the 1 s slot
                f = fmt_of(m.proto);
                start = (f.div == DIV_FAST && ch == 0) ? fast_tick : slow_tick; // [R11]
                if (start)
                begin
                    m.field = build_field(m.proto, m.fine, alt_disabled_i, alt_ft_i);
                    b = msg_byte(m.proto, 5'h00, m.field, 8'h00);
                    msg_nxt[ch] = m;
                    active_nxt[ch] = 1'b1;
                    idx_nxt[ch] = 5'h00;
                    bitn_nxt[ch] = 4'h0;
                    baud_nxt[ch] = 14'(f.div - 14'h0001); // [R10]
                    cur_nxt[ch] = b;
                    csum_nxt[ch] = 8'h00;
                    shift_nxt[ch] = frame_of(b, f.parity);
                    line_nxt[ch] = 1'b0; // [R12]
                end
            end
            else
            begin
                m = msg_r[ch];
                f = fmt_of(m.proto);
                if (baud_r[ch] != 14'h0000)
                begin
                    baud_nxt[ch] = 14'(baud_r[ch] - 14'h0001);
                end
                else if (bitn_r[ch] == FRAME_LAST_BIT)
                begin
                    // checksum freezes before its own characters go out
                    cs = (idx_r[ch] < f.cks) ? 8'(csum_r[ch] + cur_r[ch]) : csum_r[ch]; // [R14]
                    csum_nxt[ch] = cs;
                    baud_nxt[ch] = 14'(f.div - 14'h0001);
                    if (idx_r[ch] == 5'(f.len - 5'h01))
                    begin
                        active_nxt[ch] = 1'b0;
                        line_nxt[ch] = 1'b1;
                    end
                    else
                    begin
                        b = msg_byte(m.proto, 5'(idx_r[ch] + 5'h01), m.field, cs);
                        idx_nxt[ch] = 5'(idx_r[ch] + 5'h01);
                        bitn_nxt[ch] = 4'h0;
                        cur_nxt[ch] = b;
                        shift_nxt[ch] = frame_of(b, f.parity);
                        line_nxt[ch] = 1'b0; // [R12]
                    end
                end
                else
                begin
                    baud_nxt[ch] = 14'(f.div - 14'h0001);
                    bitn_nxt[ch] = 4'(bitn_r[ch] + 4'h1);
                    shift_nxt[ch] = {1'b1, shift_r[ch][9:1]};
                    line_nxt[ch] = shift_r[ch][1];
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tick_cnt_r <= 24'h000000;
            dec_cnt_r <= 4'h0;
            for (int ch = 0; ch < 2; ch++)
            begin
                active_r[ch] <= 1'b0;
                idx_r[ch] <= 5'h00;
                bitn_r[ch] <= 4'h0;
                baud_r[ch] <= 14'h0000;
                shift_r[ch] <= 10'h3FF;
                cur_r[ch] <= 8'h00;
                csum_r[ch] <= 8'h00;
                line_r[ch] <= 1'b1;
                msg_r[ch] <= '{PROTO_HASH_AL, 1'b0, 48'h000000000000};
            end
        end
        else
        begin
            tick_cnt_r <= tick_cnt_nxt;
            dec_cnt_r <= dec_cnt_nxt;
            for (int ch = 0; ch < 2; ch++)
            begin
                active_r[ch] <= active_nxt[ch];
                idx_r[ch] <= idx_nxt[ch];
                bitn_r[ch] <= bitn_nxt[ch];
                baud_r[ch] <= baud_nxt[ch];
                shift_r[ch] <= shift_nxt[ch];
                cur_r[ch] <= cur_nxt[ch];
                csum_r[ch] <= csum_nxt[ch];
                line_r[ch] <= line_nxt[ch];
                msg_r[ch] <= msg_nxt[ch];
            end
        end
    end

    // no receive path exists: the link is talk-only
    assign primary_serial_out_o = line_r[0]; // [R13]
    assign diff_serial_out_o = line_r[0]; // [R6]
    assign fixed_format_serial_out_o = line_r[1];
    assign primary_busy_o = active_r[0];
    assign fixed_busy_o = active_r[1];
    assign active_proto_o = msg_r[0].proto;

    mirror_same_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R6]
        diff_serial_out_o == primary_serial_out_o)
        else $error("differential output differs from primary");
    fixed_proto_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R7]
        active_r[1] |-> msg_r[1].proto == PROTO_FIXED && !msg_r[1].fine)
        else $error("secondary output left its fixed format");
    start_bit_low_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R12]
        active_r[0] && bitn_r[0] == 4'h0 |-> primary_serial_out_o == 1'b0)
        else $error("start bit not low");
    stop_bit_high_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R12]
        active_r[0] && bitn_r[0] == FRAME_LAST_BIT |-> primary_serial_out_o == 1'b1)
        else $error("stop bit not high");
    even_parity_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R4]
        active_r[0] && msg_r[0].proto == PROTO_MGL && bitn_r[0] == 4'h8 |-> primary_serial_out_o == ^cur_r[0][6:0])
        else $error("parity bit wrong in seven-bit framing");
    proto_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R15]
        active_r[0] && $past(active_r[0]) |-> $stable(msg_r[0]))
        else $error("format changed inside a message");
    baud_reload_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R10]
        active_r[0] && baud_r[0] == 14'h0000 && !$past(active_r[0]) == 1'b0 |=>
        !active_r[0] || baud_r[0] == 14'(fmt_of(msg_r[0].proto).div - 14'h0001))
        else $error("bit period does not match protocol rate");
    idle_high_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R12]
        !active_r[0] && !$past(active_r[0]) |-> primary_serial_out_o == 1'b1)
        else $error("line not idle high between messages");
    first_char_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R1]
        $rose(active_r[0]) && msg_r[0].proto == PROTO_HASH_AL |-> cur_r[0] == 8'h23 && idx_r[0] == 5'h00)
        else $error("message does not open with hash");
    coarse_zero_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R8]
        active_r[0] && !msg_r[0].fine && msg_r[0].proto == PROTO_MGL |-> msg_r[0].field[15:0] == 16'h3030)
        else $error("100-foot step not applied");

endmodule

// ### core/samf_pkg.sv
package samf_pkg;

    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned BAUD_SLOW = 1200;
    localparam int unsigned BAUD_MID = 2400;
    localparam int unsigned BAUD_FAST = 9600;
    localparam logic [13:0] DIV_SLOW = 14'((CLK_HZ + BAUD_SLOW / 2) / BAUD_SLOW);
    localparam logic [13:0] DIV_MID = 14'((CLK_HZ + BAUD_MID / 2) / BAUD_MID);
    localparam logic [13:0] DIV_FAST = 14'((CLK_HZ + BAUD_FAST / 2) / BAUD_FAST);

    // fast message slot 100 ms, slow slot ten fast slots (1 s)
    localparam int unsigned FAST_PERIOD_MS = 100;
    localparam int unsigned FAST_PERIOD_CYC = CLK_HZ / 1000 * FAST_PERIOD_MS;
    localparam logic [3:0] SLOW_PER_FAST = 4'hA;

    localparam logic [3:0] FRAME_LAST_BIT = 4'h9;
    localparam logic [4:0] LEN_HASH = 5'h11;
    localparam logic [4:0] LEN_ALT = 5'h0A;
    localparam logic [4:0] LEN_MGL = 5'h11;
    localparam logic [4:0] LEN_PASHS = 5'h18;
    localparam logic [4:0] LEN_FIXED = 5'h0A;
    localparam logic [4:0] CKS_HASH = 5'h0E;
    localparam logic [4:0] CKS_MGL = 5'h0E;
    localparam logic [4:0] CKS_PASHS = 5'h13;
    localparam logic [4:0] CKS_NONE = 5'h1F;

    localparam int unsigned RES_COARSE_FT = 100;
    localparam int unsigned RES_FINE_FT = 10;
    localparam int unsigned RES_FIXED_FT = 1;
    localparam int unsigned FT_TO_M_NUM = 3048;
    localparam int unsigned FT_TO_M_DEN = 10000;
    localparam int unsigned FIELD_MOD = 100000;

    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [7:0] CH_STX = 8'h02;
    localparam logic [7:0] CH_ETX = 8'h03;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [87:0] HEAD_HASH = "#AL ";
    localparam logic [87:0] HEAD_MGL = "$MGL";
    localparam logic [87:0] HEAD_ALT = "ALT ";
    localparam logic [87:0] HEAD_FIXED = "ALT";
    localparam logic [87:0] HEAD_PASHS = "$PASHS,ALT,";
    localparam logic [87:0] TAIL_T25 = "T+25";
    localparam logic [39:0] DIS_ALT_FAST = "99900";
    localparam logic [39:0] DIS_ALT_SLOW = "-2500";

    typedef enum logic [2:0] {
        PROTO_HASH_AL,
        PROTO_ALT_FAST,
        PROTO_ALT_SLOW,
        PROTO_MGL,
        PROTO_PASHS,
        PROTO_FIXED
    } samf_proto_type;

    typedef struct packed {
        logic [13:0] div;
        logic parity;
        logic [4:0] len;
        logic [4:0] cks;
    } samf_fmt_type;

    typedef struct packed {
        samf_proto_type proto;
        logic fine;
        logic [47:0] field;
    } samf_msg_type;

endpackage

// ### tb/samf_rx_model.sv
`timescale 1ns/100ps
module samf_rx_model
    import samf_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic line_i,
    input wire logic [13:0] div_i,
    input wire logic seven_i,
    output logic [7:0] byte_o,
    output logic byte_valid_o,
    output logic frame_err_o
);
    logic [7:0] sh;

    // listen only: nothing is ever sent back to the talker
    initial
    begin
        byte_valid_o = 1'b0;
        frame_err_o = 1'b0;
        byte_o = 8'h00;
        sh = 8'h00;
        forever
        begin
            @(negedge line_i);
            // sample mid-bit so small edge skew cannot flip a bit
            repeat (div_i / 2) @(posedge core_clk_i);
            if (line_i !== 1'b0)
                frame_err_o = 1'b1;
            for (int i = 0; i < 8; i++)
            begin
                repeat (div_i) @(posedge core_clk_i);
                sh[i] = line_i;
            end
            repeat (div_i) @(posedge core_clk_i);
            // stop bit, and even parity in bit 7 for 7-bit framing
            if (line_i !== 1'b1 || (seven_i && ^sh !== 1'b0))
                frame_err_o = 1'b1;
            byte_o = seven_i ? {1'b0, sh[6:0]} : sh;
            byte_valid_o = 1'b1;
            @(posedge core_clk_i);
            byte_valid_o = 1'b0;
        end
    end
endmodule

// ### tb/testbench.sv
`timescale 1ns/100ps
module testbench
    import samf_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic a_n = 1'b1;
    logic b_n = 1'b1;
    logic res_n = 1'b1;
    logic sw_en = 1'b0;
    logic [2:0] sw_code = 3'h0;
    logic swr_en = 1'b0;
    logic swr_fine = 1'b0;
    logic signed [17:0] alt = 18'h02929;
    logic dis = 1'b0;
    logic pri, dif, fix, pbusy, fbusy;
    logic [2:0] aproto;
    logic [7:0] pb, db, fb;
    logic pv, dv, fv, pe, de, fe;
    logic [7:0] q_p[$], q_d[$], q_f[$];
    int mismatches = 0;
    int n_compared = 0;
    int n;
    logic [1:0] t_strap [7] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h3, 2'h3, 2'h2};
    logic [3:0] t_sw [7] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'hC, 4'hF, 4'hC};
    samf_proto_type t_pr [7] = '{PROTO_HASH_AL, PROTO_ALT_FAST, PROTO_ALT_SLOW, PROTO_MGL,
                                PROTO_PASHS, PROTO_HASH_AL, PROTO_ALT_FAST};
    // low run of the first character: start bit plus leading zero data bits
    int t_low [7] = '{int'(DIV_SLOW), int'(DIV_FAST), int'(DIV_MID), 3 * int'(DIV_SLOW),
                      2 * int'(DIV_FAST), int'(DIV_SLOW), int'(DIV_FAST)};

    // short slot keeps the wait for a message start to 200 cycles, or 2000 for the 1 s slot
    samf_framer #(.FAST_PERIOD(200)) i_samf_framer (
        .core_clk_i(clk), .rst_n_i(rst_n), .proto_strap_a_n_i(a_n), .proto_strap_b_n_i(b_n),
        .res_strap_n_i(res_n), .sw_proto_en_i(sw_en), .sw_proto_i(sw_code), .sw_res_en_i(swr_en),
        .sw_res_fine_i(swr_fine), .alt_ft_i(alt), .alt_disabled_i(dis), .primary_serial_out_o(pri),
        .diff_serial_out_o(dif), .fixed_format_serial_out_o(fix), .primary_busy_o(pbusy),
        .fixed_busy_o(fbusy), .active_proto_o(aproto));
    samf_rx_model i_samf_rx_model (.core_clk_i(clk), .line_i(pri), .div_i(DIV_FAST),
        .seven_i(1'b0), .byte_o(pb), .byte_valid_o(pv), .frame_err_o(pe));
    samf_rx_model i_samf_rx_model_d (.core_clk_i(clk), .line_i(dif), .div_i(DIV_FAST),
        .seven_i(1'b0), .byte_o(db), .byte_valid_o(dv), .frame_err_o(de));
    samf_rx_model i_samf_rx_model_f (.core_clk_i(clk), .line_i(fix), .div_i(DIV_FAST),
        .seven_i(1'b0), .byte_o(fb), .byte_valid_o(fv), .frame_err_o(fe));

    initial
    begin
        forever
            #50 clk = ~clk;
    end

    task automatic check(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1)
        begin
            mismatches++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask

    task automatic check_msg(input logic [7:0] q[$], input string exp, input string who);
        check(q.size() >= exp.len(), {who, " message short"});
        for (int i = 0; i < exp.len() && i < q.size(); i++)
            check(q[i] === 8'(exp[i]), {who, " byte wrong"});
    endtask

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(negedge clk)
    begin
        if (pv === 1'b1)
            q_p.push_back(pb);
        if (dv === 1'b1)
            q_d.push_back(db);
        if (fv === 1'b1)
            q_f.push_back(fb);
        if (rst_n === 1'b1)
            check(dif === pri, "differential line differs");
    end

    // bounded hang guard, past the roughly 170k cycles of the tests
    initial
    begin
        repeat (200000) @(posedge clk);
        mismatches++;
        wrap_up();
    end

    initial
    begin
        b_n = 1'b0;
        repeat (8) @(negedge clk);
        check(pri === 1'b1 && fix === 1'b1 && pbusy === 1'b0 && aproto === 3'h0, "reset values");
        rst_n = 1'b1;
        n = 0;
        while (pbusy !== 1'b1 && n < 3000)
        begin
            @(negedge clk);
            n++;
        end
        check(pbusy === 1'b1, "no primary message");
        // change strap a, the resolution strap and the software resolution while the message runs, then put back all but swr_fine
        repeat (2000) @(negedge clk);
        a_n = 1'b0;
        res_n = 1'b0;
        swr_en = 1'b1;
        swr_fine = 1'b1;
        repeat (100) @(negedge clk);
        check(aproto === 3'(PROTO_ALT_FAST), "format switched mid-message");
        a_n = 1'b1;
        res_n = 1'b1;
        swr_en = 1'b0;
        n = 0;
        while (pbusy !== 1'b0 && n < 120000)
        begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (fbusy !== 1'b0 && n < 120000)
        begin
            @(negedge clk);
            n++;
        end
        check_msg(q_p, "ALT 10500\015", "primary");
        check_msg(q_d, "ALT 10500\015", "differential");
        check_msg(q_f, "ALT+10537\015", "fixed");
        check(pe === 1'b0 && de === 1'b0 && fe === 1'b0, "character framing");
        // a reset in mid-message must leave the primary line idle
        for (int k = 0; k < 7; k++)
        begin
            rst_n = 1'b0;
            {a_n, b_n} = t_strap[k];
            {sw_en, sw_code} = t_sw[k];
            repeat (8) @(negedge clk);
            check(pri === 1'b1 && pbusy === 1'b0, "line not idle in reset");
            rst_n = 1'b1;
            n = 0;
            while (pbusy !== 1'b1 && n < 25000)
            begin
                @(negedge clk);
                n++;
            end
            check(aproto === 3'(t_pr[k]), "protocol choice");
            n = 0;
            while (pri === 1'b0 && n < 30000)
            begin
                @(negedge clk);
                n++;
            end
            check(n == t_low[k], "bit time");
        end
        wrap_up();
    end
endmodule
